// [core/rcr_pkg.sv]
// Purpose: constants shared by the reset cause recorder
// Assumes: APB slave, 32-bit data, byte addresses
// Notes: flag layout follows the cause register bit order
// Operation
// - each reset event except power-on and brown-out updates only its own cause, time-out and sleep flags
// - power-on restarts at 0000h, sets time-out/sleep, clears power-on and stack
// - brown-out restarts at 0000h, clears brownout and stack, sets pin/instr/to/sleep
// - watchdog reset while awake clears watchdog and time-out flags
// - watchdog in sleep wakes at next instruction, clears time-out and sleep
// - interrupt wake sets time-out, clears sleep, continues at next instruction
// - interrupt wake with global enable runs next instruction then vectors 0004h
// - pin reset while awake clears pin-reset flag, restarts at 0000h
// - pin reset in sleep clears pin flag, sets time-out, clears sleep
// - reset instruction clears instruction-reset flag, restarts at 0000h
// - enabled stack overflow resets to 0000h and sets overflow flag
// - enabled stack underflow resets to 0000h and sets underflow flag
// - apart from power-on and brown-out, hardware only clears the cause flags, only sets stack flags
// - after power-on/brown-out flag values fixed; bit 5 reads zero
// - stack faults reset only while the stack reset enable is set
package rcr_pkg;
  localparam logic [11:0] ADDR_CAUSE = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_BORCTL = 12'h008;
  localparam logic [11:0] ADDR_WDTCTL = 12'h00c;
  localparam logic [11:0] ADDR_CONFIG = 12'h010;
  localparam logic [11:0] ADDR_IRQ_ST = 12'h014;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h018;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h01c;
  localparam int B_OVF = 7;
  localparam int B_UNF = 6;
  localparam int B_WDT = 4;
  localparam int B_PIN = 3;
  localparam int B_INS = 2;
  localparam int B_POR = 1;
  localparam int B_BOR = 0;
  localparam int B_TO = 4;
  localparam int B_SLP = 3;
  localparam logic [7:0] CAUSE_WMASK = 8'hdf;
  localparam logic [7:0] CAUSE_POR_VAL = 8'h1c;
  localparam logic [7:0] STATUS_POR_VAL = 8'h18;
  localparam logic [7:0] BORCTL_RST = 8'h80;
  localparam logic [7:0] BORCTL_WMASK = 8'hc0;
  localparam logic [7:0] WDTCTL_RST = 8'h00;
  localparam logic [7:0] WDTCTL_WMASK = 8'h3f;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_VECTOR = 16'h0004;
  localparam int NEV = 10;
endpackage : rcr_pkg

// [core/rcr_top.sv]
// Purpose: reset cause recorder with restart address selection
// Assumes: event inputs are one-cycle pulses synchronous to MCLK
// Notes: RST_N models power-on; brown-out is a separate event input
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module rcr_top (
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // reset and wake sources
  input wire logic EV_BROWNOUT,
  input wire logic EV_WATCHDOG,
  input wire logic EV_PIN,
  input wire logic EV_INSTR,
  input wire logic EV_STK_OVF,
  input wire logic EV_STK_UNF,
  input wire logic EV_IRQ_WAKE,
  input wire logic EV_SLEEP,
  input wire logic [15:0] CUR_PC,
  // core side
  output logic CORE_RESET,
  output logic [15:0] RESTART_PC,
  output logic RESTART_VALID,
  output logic VECTOR_PENDING,
  output logic IRQ
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] cause_r;
  logic [7:0] status_r;
  logic [7:0] borctl_r;
  logic [7:0] wdtctl_r;
  logic stack_reset_enable_r;
  logic global_irq_enable_r;
  logic [9:0] irq_st_r;
  logic [9:0] irq_en_r;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic sleep_now;
  logic stk_ovf_rst;
  logic stk_unf_rst;
  logic wdt_rst;
  logic wdt_wake;
  logic pin_rst;
  logic irq_wake;
  logic any_restart;
  logic any_wake;
  logic [9:0] ev_vec;
  logic [31:0] rd_nxt;

  assign wr_en = PSEL && PENABLE && PWRITE && CE;
  assign rd_en = PSEL && PENABLE && !PWRITE && CE;
  assign sleep_now = !status_r[rcr_pkg::B_SLP];
  assign stk_ovf_rst = EV_STK_OVF && stack_reset_enable_r;
  assign stk_unf_rst = EV_STK_UNF && stack_reset_enable_r;
  assign wdt_rst = EV_WATCHDOG && !sleep_now;
  assign wdt_wake = EV_WATCHDOG && sleep_now;
  assign pin_rst = EV_PIN;
  assign irq_wake = EV_IRQ_WAKE && sleep_now;
  assign any_restart = EV_BROWNOUT || wdt_rst || pin_rst || EV_INSTR
                       || stk_ovf_rst || stk_unf_rst;
  assign any_wake = wdt_wake || irq_wake;
  assign ev_vec = {EV_SLEEP, irq_wake, wdt_wake, stk_unf_rst, stk_ovf_rst,
                   EV_INSTR, pin_rst, wdt_rst, EV_BROWNOUT, 1'b0};

  always_comb begin
    hit = 1'b1;
    rd_nxt = 32'h0000_0000;
    unique case (PADDR)
      rcr_pkg::ADDR_CAUSE: rd_nxt = {24'h0, cause_r};
      rcr_pkg::ADDR_STATUS: rd_nxt = {24'h0, status_r};
      rcr_pkg::ADDR_BORCTL: rd_nxt = {24'h0, borctl_r};
      rcr_pkg::ADDR_WDTCTL: rd_nxt = {24'h0, wdtctl_r};
      rcr_pkg::ADDR_CONFIG:
        rd_nxt = {30'h0, global_irq_enable_r, stack_reset_enable_r};
      rcr_pkg::ADDR_IRQ_ST: rd_nxt = {22'h0, irq_st_r};
      rcr_pkg::ADDR_IRQ_EN: rd_nxt = {22'h0, irq_en_r};
      rcr_pkg::ADDR_IRQ_CLR: rd_nxt = 32'h0000_0000;
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // zero wait states: every access completes at its first access cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      PREADY <= 1'b0;
    end else if (CE) begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= rd_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cause flags: only power-on initialises them, so they persist otherwise
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cause_r <= rcr_pkg::CAUSE_POR_VAL;
    end else if (CE) begin
      if (wr_en && PREADY && PADDR == rcr_pkg::ADDR_CAUSE) begin
        // software may set or clear cause and stack flags; bit 5 stays zero
        cause_r <= PWDATA[7:0] & rcr_pkg::CAUSE_WMASK;
      end
      // hardware events follow the write so an event is never lost
      if (EV_BROWNOUT) begin
        cause_r[rcr_pkg::B_BOR] <= 1'b0;
        cause_r[rcr_pkg::B_OVF] <= 1'b0;
        cause_r[rcr_pkg::B_UNF] <= 1'b0;
        cause_r[rcr_pkg::B_PIN] <= 1'b1;
        cause_r[rcr_pkg::B_INS] <= 1'b1;
      end else begin
        if (wdt_rst) cause_r[rcr_pkg::B_WDT] <= 1'b0;
        if (pin_rst) cause_r[rcr_pkg::B_PIN] <= 1'b0;
        if (EV_INSTR) cause_r[rcr_pkg::B_INS] <= 1'b0;
        if (stk_ovf_rst) cause_r[rcr_pkg::B_OVF] <= 1'b1;
        if (stk_unf_rst) cause_r[rcr_pkg::B_UNF] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core status: time-out bit 4, sleep bit 3 (1 = awake); low bits are r/w
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      status_r <= rcr_pkg::STATUS_POR_VAL;
    end else if (CE) begin
      if (wr_en && PREADY && PADDR == rcr_pkg::ADDR_STATUS) begin
        status_r[2:0] <= PWDATA[2:0];
      end
      if (EV_SLEEP && !any_restart && !any_wake) begin
        status_r[rcr_pkg::B_SLP] <= 1'b0;
        status_r[rcr_pkg::B_TO] <= 1'b1;
      end
      if (EV_BROWNOUT) begin
        status_r[rcr_pkg::B_TO] <= 1'b1;
        status_r[rcr_pkg::B_SLP] <= 1'b1;
      end else if (wdt_wake) begin
        status_r[rcr_pkg::B_TO] <= 1'b0;
        status_r[rcr_pkg::B_SLP] <= 1'b0;
      end else if (wdt_rst) begin
        status_r[rcr_pkg::B_TO] <= 1'b0;
      end else if (pin_rst && sleep_now) begin
        // cleared sleep flag here matches the printed table
        status_r[rcr_pkg::B_TO] <= 1'b1;
        status_r[rcr_pkg::B_SLP] <= 1'b0;
      end else if (irq_wake) begin
        status_r[rcr_pkg::B_TO] <= 1'b1;
        status_r[rcr_pkg::B_SLP] <= 1'b0;
      end // other restart sources leave both untouched
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // restart address selection and core reset pulse
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CORE_RESET <= 1'b1;
      RESTART_PC <= rcr_pkg::PC_RESET;
      RESTART_VALID <= 1'b1;
      VECTOR_PENDING <= 1'b0;
    end else if (CE) begin
      CORE_RESET <= any_restart;
      RESTART_VALID <= any_restart || any_wake;
      VECTOR_PENDING <= 1'b0;
      if (any_restart) begin
        RESTART_PC <= rcr_pkg::PC_RESET;
      end else if (any_wake) begin
        RESTART_PC <= CUR_PC + 16'h0001;
        // the core runs the next instruction, then jumps to PC_VECTOR
        VECTOR_PENDING <= irq_wake && global_irq_enable_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      borctl_r <= rcr_pkg::BORCTL_RST;
      wdtctl_r <= rcr_pkg::WDTCTL_RST;
      stack_reset_enable_r <= 1'b0;
      global_irq_enable_r <= 1'b0;
      irq_en_r <= 10'h000;
    end else if (CE) begin
      if (wr_en && PREADY) begin
        unique case (PADDR)
          rcr_pkg::ADDR_BORCTL:
            borctl_r <= PWDATA[7:0] & rcr_pkg::BORCTL_WMASK;
          rcr_pkg::ADDR_WDTCTL:
            wdtctl_r <= PWDATA[7:0] & rcr_pkg::WDTCTL_WMASK;
          rcr_pkg::ADDR_CONFIG: begin
            stack_reset_enable_r <= PWDATA[0];
            global_irq_enable_r <= PWDATA[1];
          end
          rcr_pkg::ADDR_IRQ_EN: irq_en_r <= PWDATA[9:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky event status; a set in the clear cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < rcr_pkg::NEV; gi = gi + 1) begin : g_ev
      always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
          irq_st_r[gi] <= 1'b0;
        end else if (CE) begin
          if (ev_vec[gi]) begin
            irq_st_r[gi] <= 1'b1;
          end else if (wr_en && PREADY && PADDR == rcr_pkg::ADDR_IRQ_CLR
                       && PWDATA[gi]) begin
            irq_st_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(irq_st_r & irq_en_r);
    end
  end

endmodule : rcr_top

// [testbench/rcr_monitor.sv]
// Purpose: port-level checker for the reset cause recorder
// Assumes: single clock domain, events are one-cycle pulses
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
module rcr_monitor (
  // clock and control
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // events and core side
  input wire logic EV_BROWNOUT,
  input wire logic EV_PIN,
  input wire logic EV_INSTR,
  input wire logic EV_IRQ_WAKE,
  input wire logic CORE_RESET,
  input wire logic [15:0] RESTART_PC,
  input wire logic RESTART_VALID,
  input wire logic IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  //////////////////////////////////////////////////////////////////
  sequence s_setup; PSEL && !PENABLE && CE; endsequence
  sequence s_rst_ev; (EV_BROWNOUT || EV_PIN || EV_INSTR) && CE; endsequence
  sequence s_zero_pc; RESTART_VALID && RESTART_PC == 16'h0000; endsequence
  property p_ready; s_setup |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_ready_src;
    PREADY |-> $past(PSEL) && !$past(PENABLE);
  endproperty
  a_ready_src: assert property (p_ready_src)
    else $error("stray ready");
  property p_ready_one; PREADY && CE |=> !PREADY; endproperty
  a_ready_one: assert property (p_ready_one) else $error("long ready");
  property p_err; PSLVERR && !PWRITE |-> PREADY && PRDATA == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad refusal");
  property p_restart;
    s_rst_ev |-> ##[1:2] (CORE_RESET ##0 s_zero_pc);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_pair; CORE_RESET |-> s_zero_pc; endproperty
  a_pair: assert property (p_pair) else $error("reset pc wrong");
  property p_core_one; CORE_RESET && CE |=> !CORE_RESET; endproperty
  a_core_one: assert property (p_core_one) else $error("long reset");
  property p_wake; EV_IRQ_WAKE && CE |-> ##[1:2] (RESTART_VALID && !CORE_RESET);
  endproperty
  a_wake: assert property (p_wake) else $error("wake reset");
  property p_freeze; !CE |=> $stable(PRDATA) && $stable(IRQ); endproperty
  a_freeze: assert property (p_freeze)
    else $error("moved while frozen");
endmodule : rcr_monitor

bind rcr_top rcr_monitor rcr_monitor_i (.MCLK(MCLK), .RST_N(RST_N), .CE(CE),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EV_BROWNOUT(EV_BROWNOUT),
  .EV_PIN(EV_PIN), .EV_INSTR(EV_INSTR), .EV_IRQ_WAKE(EV_IRQ_WAKE),
  .CORE_RESET(CORE_RESET), .RESTART_PC(RESTART_PC),
  .RESTART_VALID(RESTART_VALID), .IRQ(IRQ));

// [testbench/test_reset_cause_recorder.sv]
// Purpose: self-checking bench for the reset cause recorder
// Assumes: events driven as single-cycle pulses, fixed program counter
// Notes: row results are cumulative, so the row order matters
`timescale 1ns/1ps
module test_reset_cause_recorder;
  logic MCLK = 1'h0, RST_N = 1'h0, CE = 1'h1, PSEL = 1'h0, PENABLE = 1'h0;
  logic PWRITE = 1'h0, PREADY, PSLVERR, CORE_RESET, RESTART_VALID, IRQ, vpend;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [15:0] RESTART_PC, pc;
  logic [7:0] evs = 8'h00;
  logic sr, sv, vp, er;
  int err_count = 0, num_checks = 0, cyc = 0;
  // event, core reset, restart valid, cause, status
  logic [25:0] rows [10] = '{{8'h10,2'h3,8'h1b,8'h18}, {8'h40,2'h3,8'h0b,8'h08},
    {8'h01,2'h0,8'h0b,8'h10}, {8'h20,2'h3,8'h03,8'h10}, {8'h01,2'h0,8'h03,8'h10},
    {8'h40,2'h1,8'h03,8'h00}, {8'h01,2'h0,8'h03,8'h10}, {8'h02,2'h1,8'h03,8'h10},
    {8'h80,2'h3,8'h0e,8'h18}, {8'h20,2'h3,8'h06,8'h18}};
  always #2.5 MCLK = ~MCLK;
  rcr_top rcr_top_i (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EV_BROWNOUT(evs[7]), .EV_WATCHDOG(evs[6]), .EV_PIN(evs[5]),
    .EV_INSTR(evs[4]), .EV_STK_OVF(evs[3]), .EV_STK_UNF(evs[2]),
    .EV_IRQ_WAKE(evs[1]), .EV_SLEEP(evs[0]), .CUR_PC(16'h1234),
    .CORE_RESET(CORE_RESET), .RESTART_PC(RESTART_PC),
    .RESTART_VALID(RESTART_VALID), .VECTOR_PENDING(vpend), .IRQ(IRQ));
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  // setup then access; request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'h1;
    // no assumed latency: ready ends this wait, only the bench timeout bounds it
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'h1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  // one-cycle event, then watch the core side for four edges
  task automatic pulse(input logic [7:0] e);
    @(posedge MCLK);
    evs <= e;
    @(posedge MCLK);
    evs <= 8'h00;
    sr = 1'h0;
    sv = 1'h0;
    vp = 1'h0;
    repeat (4) begin
      @(posedge MCLK);
      if (CORE_RESET === 1'h1) sr = 1'h1;
      if (vpend === 1'h1) vp = 1'h1;
      if (RESTART_VALID === 1'h1) begin
        sv = 1'h1;
        pc = RESTART_PC;
      end
    end
  endtask : pulse
  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge MCLK);
    RST_N <= 1'h1;
    rchk(rcr_pkg::ADDR_CAUSE, 32'h1c);
    rchk(rcr_pkg::ADDR_STATUS, 32'h18);
    rchk(rcr_pkg::ADDR_BORCTL, 32'h80);
    apb(1'h1, rcr_pkg::ADDR_CAUSE, 32'h1f);
    rchk(rcr_pkg::ADDR_CAUSE, 32'h1f);
    apb(1'h1, rcr_pkg::ADDR_CONFIG, 32'h2);
    for (int i = 0; i < 10; i++) begin
      pulse(rows[i][25:18]);
      chk(sr, rows[i][17]);
      chk(sv, rows[i][16]);
      if (sv === 1'h1) chk(pc, sr ? 16'h0000 : 16'h1235);
      chk(vp, rows[i][25:18] == 8'h02);
      rchk(rcr_pkg::ADDR_CAUSE, rows[i][15:8]);
      rchk(rcr_pkg::ADDR_STATUS, rows[i][7:0]);
    end
    // stack faults, with the interrupt raised, cleared and masked
    apb(1'h1, rcr_pkg::ADDR_IRQ_CLR, 32'h3ff);
    apb(1'h1, rcr_pkg::ADDR_IRQ_EN, 32'h20);
    pulse(8'h08);
    chk(sr, 1'h0);
    rchk(rcr_pkg::ADDR_CAUSE, 32'h06);
    apb(1'h1, rcr_pkg::ADDR_CONFIG, 32'h1);
    apb(1'h1, rcr_pkg::ADDR_IRQ_CLR, 32'h3ff);
    pulse(8'h08);
    chk(sr, 1'h1);
    chk(IRQ, 1'h1);
    rchk(rcr_pkg::ADDR_CAUSE, 32'h86);
    apb(1'h1, rcr_pkg::ADDR_IRQ_CLR, 32'h20);
    repeat (2) @(posedge MCLK);
    chk(IRQ, 1'h0);
    apb(1'h1, rcr_pkg::ADDR_IRQ_EN, 32'h0);
    pulse(8'h04);
    chk(sr, 1'h1);
    chk(IRQ, 1'h0);
    rchk(rcr_pkg::ADDR_IRQ_ST, 32'h40);
    rchk(rcr_pkg::ADDR_CAUSE, 32'hc6);
    apb(1'h1, rcr_pkg::ADDR_CAUSE, 32'h3f);
    rchk(rcr_pkg::ADDR_CAUSE, 32'h1f);
    apb(1'h1, rcr_pkg::ADDR_WDTCTL, 32'hff);
    rchk(rcr_pkg::ADDR_WDTCTL, 32'h3f);
    rchk(12'h020, 32'h0);
    chk(er, 1'h1);
    // frozen clock enable, then a power-on in mid-run
    CE <= 1'h0;
    pulse(8'h20);
    CE <= 1'h1;
    chk(sr, 1'h0);
    rchk(rcr_pkg::ADDR_CAUSE, 32'h1f);
    RST_N <= 1'h0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'h1;
    rchk(rcr_pkg::ADDR_CAUSE, 32'h1c);
    rchk(rcr_pkg::ADDR_STATUS, 32'h18);
    tally_and_finish();
  end
endmodule : test_reset_cause_recorder
